/* File: unit_err_regs.vh */
// register offsets, bit positions, reset values and timing counts for the unit error block
`ifndef UNIT_ERR_REGS_VH
`define UNIT_ERR_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define UE_STATUS_OFS      12'h140
`define UE_MASK_OFS        12'h144
`define UE_IRQ_STAT_OFS    12'h150
`define UE_IRQ_EN_OFS      12'h154
`define UE_IRQ_CLR_OFS     12'h158
`define UE_CTRL_OFS        12'h15c
`define UE_STATE_OFS       12'h160

// ************************************************************
// status and mask bit positions
// ************************************************************
`define UE_BIT_LINK_DOWN   11
`define UE_BIT_DDQ_PAR     10
`define UE_BIT_LUT_PAR     9
`define UE_BIT_LRB_DATA    8
`define UE_BIT_LRB_HDR     7
`define UE_BIT_LRB_CTL     6
`define UE_BIT_DLLP_TO     5
`define UE_BIT_SMB_CLTO    2
`define UE_BIT_SMB_NAK     1
`define UE_BIT_SMB_LA      0

// writable and settable bits of status; 4 and 3 reserved
`define UE_IMPL_MASK       16'h0fe7

// ************************************************************
// reset values
// ************************************************************
`define UE_STATUS_RST      16'h0000
`define UE_MASK_RST        16'h0000
`define UE_IRQ_EN_RST      16'h0000

// ************************************************************
// timing
// ************************************************************
`define UE_SMB_LOW_MS      25
`define UE_CLK_KHZ         100000
`define UE_SMB_LOW_CYC     (`UE_SMB_LOW_MS * `UE_CLK_KHZ)

`endif

/* File: smb_low_timer.v */
// smbus clock low timeout detector
`timescale 1ns/100ps
`default_nettype none

module smb_low_timer
#(
  parameter [31:0] LIMIT = 32'd2500000
)
(
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        scl_low,
  output reg         timeout_pulse
);

  reg [31:0] count_q;
  reg        fired_q;

  // counts while low; one pulse per low period so a stuck line is one event
  always @(posedge clk_sys)
  begin
    if (sys_rst || !scl_low)
    begin
      count_q       <= 32'h0000_0000;
      fired_q       <= 1'b0;
      timeout_pulse <= 1'b0;
    end
    else
    begin
      timeout_pulse <= 1'b0;
      if (count_q < LIMIT)
        count_q <= count_q + 32'h0000_0001;
      else if (!fired_q)
      begin
        fired_q       <= 1'b1;
        timeout_pulse <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: pcie_unit_error_status.v */
// unit error status, mask and interrupt logic for a pcie root port
//
// Contract
// [RULE_01] set link down bit when link moves from up to down
// [RULE_02] no link down bit when software caused the drop
// [RULE_03] status bits clear only on a written one; zero leaves them
// [RULE_04] status survives reset; zero only at power-up
// [RULE_05] set bit 10 on downstream data queue parity error
// [RULE_06] lookup parity: set bit 9, stop transfers, force retraining
// [RULE_07] lookup parity reported again on every access to bad row
// [RULE_08] set bit 8 on retry buffer data parity error
// [RULE_09] retry buffer parity checked only during a replay
// [RULE_10] header parity: set bit 7, mark current bad, stop transfers
// [RULE_11] control parity: set bit 6, fatal, stop data transfers
// [RULE_12] set bit 5 on flow control dllp timeout, not ack/nak
// [RULE_13] set bit 2 when smbus clock low over 25 ms
// [RULE_14] set bit 1 on unexpected smbus nak
// [RULE_15] set bit 0, correctable, on lost smbus arbitration
// [RULE_16] masked errors still recorded but not logged to first/next
// [RULE_17] reserved bits 4 and 3 read zero, ignore writes
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "unit_err_regs.vh"

module pcie_unit_error_status
#(
  parameter [31:0] SMB_LOW_CYCLES = `UE_SMB_LOW_CYC
)
(
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        por_rst,
  // register port
  input  wire [11:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // link and transaction layer events
  input  wire        link_up,
  input  wire        sec_bus_reset,
  input  wire        link_disable,
  input  wire        loopback_en,
  input  wire        ddq_parity_err,
  input  wire        lut_access,
  input  wire        lut_parity_bad,
  input  wire        replay_active,
  input  wire        link_retry_buffer_data_par,
  input  wire        link_retry_buffer_hdr_par,
  input  wire        link_retry_buffer_ctl_par,
  input  wire        fc_dllp_timeout,
  input  wire        acknak_timeout,
  // smbus side
  input  wire        smb_scl_in,
  input  wire        smbus_unexpected_nak,
  input  wire        smbus_lost_arbitration,
  // consequences
  output reg         transfer_halt,
  output reg         force_retrain,
  output reg         mark_bad_tlp,
  output reg  [15:0] log_event,
  output reg         fatal_err,
  output reg         correctable_err,
  output reg         irq
);

  // ************************************************************
  // state
  // ************************************************************
  reg  [15:0] status_q;
  wire [15:0] status_d;
  wire [15:0] irq_stat_d;
  wire        halt_cause;
  reg  [15:0] mask_q;
  reg  [15:0] irq_stat_q;
  reg  [15:0] irq_en_q;
  reg         link_up_q;
  reg         halt_q;
  reg  [1:0]  scl_sync_q;
  reg  [15:0] events;
  reg         clto_pulse_q;
  wire        clto_pulse;
  wire        w1c_status;
  wire        wr_irq_clr;

  // positions that hold a real error; the rest are tied off per bit below
  localparam [15:0] IMPL_BITS = `UE_IMPL_MASK;

  // scl comes from a pin: two flops before the timer reads it
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      scl_sync_q <= 2'b11;
    else
      scl_sync_q <= {scl_sync_q[0], smb_scl_in};
  end

  smb_low_timer
  #(
    .LIMIT         (SMB_LOW_CYCLES)
  )
  u_smb_low_timer
  (
    .clk_sys       (clk_sys),
    .sys_rst       (sys_rst),
    .scl_low       (~scl_sync_q[1]),
    .timeout_pulse (clto_pulse)
  );

  // ************************************************************
  // event collection
  // ************************************************************

  // previous link state, so the down edge is seen once
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      link_up_q <= 1'b0;
    else
      link_up_q <= link_up;
  end

  always @(posedge clk_sys)
  begin
    clto_pulse_q <= clto_pulse;
  end

  // one event vector in status layout; bits 4 and 3 never set
  always @*
  begin
    events = 16'h0000;
    events[`UE_BIT_LINK_DOWN] = link_up_q && !link_up
                               && !(sec_bus_reset || link_disable || loopback_en); // [RULE_01] [RULE_02]
    events[`UE_BIT_DDQ_PAR]   = ddq_parity_err;                                     // [RULE_05]
    // a bad row reports each time it is touched, so repeats are expected
    events[`UE_BIT_LUT_PAR]   = lut_access && lut_parity_bad;                       // [RULE_06] [RULE_07]
    // retry buffer parity is only meaningful while replaying
    events[`UE_BIT_LRB_DATA]  = replay_active && link_retry_buffer_data_par;        // [RULE_08] [RULE_09]
    events[`UE_BIT_LRB_HDR]   = replay_active && link_retry_buffer_hdr_par;         // [RULE_10] [RULE_09]
    events[`UE_BIT_LRB_CTL]   = replay_active && link_retry_buffer_ctl_par;         // [RULE_11] [RULE_09]
    events[`UE_BIT_DLLP_TO]   = fc_dllp_timeout && !acknak_timeout;                 // [RULE_12]
    events[`UE_BIT_SMB_CLTO]  = clto_pulse_q;                                       // [RULE_13]
    events[`UE_BIT_SMB_NAK]   = smbus_unexpected_nak;                               // [RULE_14]
    events[`UE_BIT_SMB_LA]    = smbus_lost_arbitration;                             // [RULE_15]
  end

  // ************************************************************
  // register decode
  // ************************************************************
  assign w1c_status = reg_wr && (reg_addr == `UE_STATUS_OFS);
  assign wr_irq_clr = reg_wr && (reg_addr == `UE_IRQ_CLR_OFS);

  // ************************************************************
  // per-bit next values
  // ************************************************************

  // one cell per status position, shared by the error and interrupt banks;
  // reserved cells are tied to zero so a write there can never stick
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_bit
      if (IMPL_BITS[gi])
      begin : g_live
        // set wins over a same-cycle clear, so an event is never lost
        assign status_d[gi]   = events[gi]
                                | (status_q[gi] & ~(w1c_status & reg_wdata[gi]));   // [RULE_03]
        // the interrupt copy clears through its own write-one register
        assign irq_stat_d[gi] = events[gi]
                                | (irq_stat_q[gi] & ~(wr_irq_clr & reg_wdata[gi]));
      end
      else
      begin : g_resv
        // reserved position: reads zero whatever software writes
        assign status_d[gi]   = 1'b0;                                               // [RULE_17]
        assign irq_stat_d[gi] = 1'b0;
      end
    end
  endgenerate

  // ************************************************************
  // sticky status and mask
  // ************************************************************

  // status is sticky: only the power-on reset clears it, sys_rst does not
  always @(posedge clk_sys)
  begin
    if (por_rst)
      status_q <= `UE_STATUS_RST;   // [RULE_04]
    else
      status_q <= status_d;         // [RULE_04]
  end

  // mask bits are sticky in the same way as the status they qualify
  always @(posedge clk_sys)
  begin
    if (por_rst)
      mask_q <= `UE_MASK_RST;
    else if (reg_wr && (reg_addr == `UE_MASK_OFS))
      mask_q <= reg_wdata[15:0] & `UE_IMPL_MASK;
  end

  // ************************************************************
  // interrupt bank
  // ************************************************************

  // interrupt status: same layout as the error status, but cleared by sys_rst
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_stat_q <= 16'h0000;
    else
      irq_stat_q <= irq_stat_d;
  end

  // enable register; reserved and upper positions are not writable
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_en_q <= `UE_IRQ_EN_RST;
    else if (reg_wr && (reg_addr == `UE_IRQ_EN_OFS))
      irq_en_q <= reg_wdata[15:0] & `UE_IMPL_MASK;
  end

  // level output from a flop, one cycle behind the status it reflects
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_en_q);
  end

  // ************************************************************
  // fatal handling and logging
  // ************************************************************

  // every hit that leaves the datapath unusable
  assign halt_cause = events[`UE_BIT_LUT_PAR]
                      | events[`UE_BIT_LRB_HDR]
                      | events[`UE_BIT_LRB_CTL];   // [RULE_06] [RULE_10] [RULE_11]

  // once a fatal parity hits, transfers stay stopped until reset;
  // pointers or tables are suspect, so there is no safe way to resume
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      halt_q        <= 1'b0;
      transfer_halt <= 1'b0;
    end
    else
    begin
      halt_q        <= halt_q | halt_cause;        // [RULE_06] [RULE_10] [RULE_11]
      transfer_halt <= halt_q | halt_cause;        // [RULE_06] [RULE_10] [RULE_11]
    end
  end

  // one retrain request per lookup hit; repeats follow repeated accesses
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      force_retrain <= 1'b0;
    else
      force_retrain <= events[`UE_BIT_LUT_PAR];    // [RULE_06]
  end

  // the transaction in flight is marked bad on a header hit
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      mark_bad_tlp <= 1'b0;
    else
      mark_bad_tlp <= events[`UE_BIT_LRB_HDR];     // [RULE_10]
  end

  // masked errors are recorded above but kept from first/next logs
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      log_event <= 16'h0000;
    else
      log_event <= events & ~mask_q;               // [RULE_16]
  end

  // each fatal source is gated by its own mask bit only
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      fatal_err <= 1'b0;
    else
      fatal_err <= (events[`UE_BIT_LRB_HDR] & ~mask_q[`UE_BIT_LRB_HDR])
                   | (events[`UE_BIT_LRB_CTL] & ~mask_q[`UE_BIT_LRB_CTL]); // [RULE_10] [RULE_11] [RULE_16]
  end

  // lost arbitration is the only correctable source in this block
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      correctable_err <= 1'b0;
    else
      correctable_err <= events[`UE_BIT_SMB_LA] & ~mask_q[`UE_BIT_SMB_LA];  // [RULE_15]
  end

  // ************************************************************
  // read port: data one cycle after the strobe, zero otherwise
  // ************************************************************
  always @(posedge clk_sys)
  begin
    if (sys_rst || !reg_rd)
      reg_rdata <= 32'h0000_0000;
    else
    begin
      case (reg_addr)
        `UE_STATUS_OFS:   reg_rdata <= {16'h0000, status_q};    // [RULE_17]
        `UE_MASK_OFS:     reg_rdata <= {16'h0000, mask_q};
        `UE_IRQ_STAT_OFS: reg_rdata <= {16'h0000, irq_stat_q};
        `UE_IRQ_EN_OFS:   reg_rdata <= {16'h0000, irq_en_q};
        `UE_STATE_OFS:    reg_rdata <= {29'h0000_0000, link_up_q, scl_sync_q[1], halt_q};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: far_side_model.sv */
// far side model: link partner state and the smbus clock line
`timescale 1ns/100ps
`default_nettype none

module far_side_model
(
  input  wire logic clk_sys,
  input  wire logic go_down,
  input  wire logic hold_low,
  output var  logic link_up,
  output var  logic smb_scl
);
  // link stays up unless told to drop; released scl returns to its pull-up
  initial
  begin
    link_up = 1'h1;
    smb_scl = 1'h1;
  end
  always @(posedge clk_sys)
  begin
    link_up <= !go_down;
    smb_scl <= !hold_low;
  end
endmodule

`default_nettype wire

/* File: ue_asserts.sv */
// assertions on the unit error block ports
`timescale 1ns/100ps
`default_nettype none

module ue_asserts
#(
  parameter [31:0] SMB_LOW_CYCLES = 32'd20
)
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        ddq_parity_err,
  input wire logic        lut_access,
  input wire logic        lut_parity_bad,
  input wire logic        replay_active,
  input wire logic        link_retry_buffer_hdr_par,
  input wire logic        link_retry_buffer_ctl_par,
  input wire logic        smbus_lost_arbitration,
  input wire logic        transfer_halt,
  input wire logic        force_retrain,
  input wire logic        mark_bad_tlp,
  input wire logic [15:0] log_event,
  input wire logic        fatal_err,
  input wire logic        correctable_err
);
  // ****
  // event causes as the block should qualify them
  // ****
  wire lut_ev = lut_access && lut_parity_bad;
  wire hdr_ev = replay_active && link_retry_buffer_hdr_par;
  wire ctl_ev = replay_active && link_retry_buffer_ctl_par;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  retrain_now_a: assert property (lut_ev |=> force_retrain) else $error("no retrain");
  retrain_cause_a: assert property (force_retrain |-> $past(lut_ev)) else $error("stray retrain");
  halt_set_a: assert property ((hdr_ev || ctl_ev) |=> transfer_halt) else $error("no halt");
  halt_hold_a: assert property (transfer_halt |=> transfer_halt) else $error("halt dropped");
  bad_tlp_a: assert property (hdr_ev |=> mark_bad_tlp) else $error("no bad mark");
  replay_only_a: assert property ((mark_bad_tlp || fatal_err) |-> $past(hdr_ev || ctl_ev))
    else $error("fault outside replay");
  corr_cause_a: assert property (correctable_err |-> $past(smbus_lost_arbitration))
    else $error("stray correctable");
  ddq_log_a: assert property (log_event[10] |-> $past(ddq_parity_err)) else $error("stray log");
  resv_log_a: assert property (log_event[4:3] == 2'h0) else $error("reserved log");
endmodule

bind pcie_unit_error_status ue_asserts #(.SMB_LOW_CYCLES(SMB_LOW_CYCLES)) chk_i (.clk_sys, .sys_rst,
  .ddq_parity_err, .lut_access, .lut_parity_bad, .replay_active, .link_retry_buffer_hdr_par,
  .link_retry_buffer_ctl_par, .smbus_lost_arbitration, .transfer_halt, .force_retrain, .mark_bad_tlp,
  .log_event, .fatal_err, .correctable_err);

`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the unit error block
`timescale 1ns/100ps
`default_nettype none
`include "unit_err_regs.vh"

module testbench;
  logic        clk_sys = 1'h0;
  logic        sys_rst = 1'h1;
  logic        por_rst = 1'h1;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        replay = 1'h0;
  logic        acknak = 1'h0;
  logic        go_down = 1'h0;
  logic        hold_low = 1'h0;
  logic [2:0]  sw = 3'h0;
  logic [11:0] reg_addr = 12'h0;
  logic [15:0] ev = 16'h0;
  logic [15:0] lg;
  logic [15:0] log_event;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic        link_up, smb_scl, transfer_halt, force_retrain, mark_bad_tlp, fatal_err, correctable_err, irq;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          bl[8] = '{10, 9, 8, 7, 6, 5, 1, 0};

  always #5 clk_sys = ~clk_sys;

  far_side_model far (.clk_sys, .go_down, .hold_low, .link_up, .smb_scl);

  pcie_unit_error_status #(.SMB_LOW_CYCLES(32'd20)) uut (.clk_sys, .sys_rst, .por_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_up, .sec_bus_reset(sw[0]), .link_disable(sw[1]),
    .loopback_en(sw[2]), .ddq_parity_err(ev[10]), .lut_access(ev[9]), .lut_parity_bad(ev[9]),
    .replay_active(replay), .link_retry_buffer_data_par(ev[8]), .link_retry_buffer_hdr_par(ev[7]),
    .link_retry_buffer_ctl_par(ev[6]), .fc_dllp_timeout(ev[5]), .acknak_timeout(acknak),
    .smb_scl_in(smb_scl), .smbus_unexpected_nak(ev[1]), .smbus_lost_arbitration(ev[0]),
    .transfer_halt, .force_retrain, .mark_bad_tlp, .log_event, .fatal_err, .correctable_err, .irq);

  // ****
  // bus cycles and comparison
  // ****
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_compared++;
      if (g !== e)
      begin
        errors++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // strobe drops with a spare cycle so the next task never re-drives it in one step
  task wr(input [11:0] a, input [31:0] v);
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      tick(1);
      reg_wr <= 1'h0;
      tick(1);
    end
  endtask
  task rd(input [11:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'h1;
      tick(1);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
      tick(1);
    end
  endtask
  task pulse(input [15:0] e);
    begin
      ev <= e;
      tick(1);
      ev <= 16'h0;
      #1 lg = log_event;
      tick(2);
    end
  endtask
  // read status, compare, then clear every bit
  task st(input string nm, input [15:0] e);
    begin
      rd(`UE_STATUS_OFS);
      chk(nm, {16'h0, e}, d);
      wr(`UE_STATUS_OFS, 32'hffff);
    end
  endtask

  // ****
  // scenarios
  // ****
  task t_bits;
    begin
      replay <= 1'h1;
      foreach (bl[i])
      begin
        pulse(16'h1 << bl[i]);
        st("event bit", 16'h1 << bl[i]);
      end
      pulse(16'h200);
      st("lut again", 16'h200);
      replay <= 1'h0;
      pulse(16'h1c0);
      st("no replay", 16'h0);
      acknak <= 1'h1;
      pulse(16'h20);
      acknak <= 1'h0;
      st("acknak", 16'h0);
    end
  endtask
  // last pass has no software cause, so only it may record a drop
  task t_link;
    for (int i = 0; i < 4; i++)
    begin
      sw <= 3'(1 << i);
      tick(1);
      go_down <= 1'h1;
      tick(3);
      go_down <= 1'h0;
      tick(3);
      sw <= 3'h0;
      st("link drop", (i == 3) ? 16'h800 : 16'h0);
    end
  endtask
  task t_w1c;
    begin
      pulse(16'h402);
      wr(`UE_STATUS_OFS, 32'h0);
      rd(`UE_STATUS_OFS);
      chk("write zero", 32'h402, d);
      wr(`UE_STATUS_OFS, 32'h400);
      sys_rst <= 1'h1;
      tick(1);
      sys_rst <= 1'h0;
      tick(1);
      st("after reset", 16'h2);
      wr(`UE_MASK_OFS, 32'hffffffff);
      rd(`UE_MASK_OFS);
      chk("mask bits", 32'h0fe7, d);
      pulse(16'h400);
      chk("masked log", 32'h0, lg[10]);
      wr(`UE_MASK_OFS, 32'h0);
      pulse(16'h400);
      chk("open log", 32'h1, lg[10]);
      st("masked kept", 16'h400);
    end
  endtask
  task t_smb;
    begin
      hold_low <= 1'h1;
      tick(15);
      hold_low <= 1'h0;
      tick(5);
      st("short low", 16'h0);
      hold_low <= 1'h1;
      tick(30);
      hold_low <= 1'h0;
      tick(5);
      st("long low", 16'h4);
    end
  endtask
  // only bit 10 is enabled, so clearing it must drop the line despite bit 0
  task t_irq;
    begin
      wr(`UE_IRQ_CLR_OFS, 32'hffff);
      wr(`UE_IRQ_EN_OFS, 32'h400);
      @(negedge clk_sys);
      chk("irq idle", 32'h0, irq);
      pulse(16'h401);
      @(negedge clk_sys);
      chk("irq on", 32'h1, irq);
      rd(`UE_IRQ_STAT_OFS);
      chk("irq stat", 32'h401, d);
      wr(`UE_IRQ_CLR_OFS, 32'h400);
      tick(2);
      @(negedge clk_sys);
      chk("irq off", 32'h0, irq);
      rd(`UE_CTRL_OFS);
      chk("unmapped", 32'h0, d);
      wr(`UE_IRQ_CLR_OFS, 32'hffff);
      st("irq kept status", 16'h401);
    end
  endtask

  task give_verdict;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      give_verdict;
    end
  end

  initial
  begin
    tick(4);
    sys_rst <= 1'h0;
    por_rst <= 1'h0;
    tick(1);
    st("power up", 16'h0);
    t_bits;
    t_link;
    t_w1c;
    t_smb;
    t_irq;
    give_verdict;
  end
endmodule

`default_nettype wire
